/* File: hdl/psf_pkg.sv */
// Purpose: shared constants and types for the pipe select and fence block
// Assumes: commands arrive one dword at a time from a fetch unit
// Notes: fence units are 512-bit words of the shared return storage
package psf_pkg;
  // command header decode
  localparam logic [2:0] PSF_TYPE_GFX = 3'h3;
  localparam logic [1:0] PSF_SUBTYPE_COMMON = 2'h0;
  localparam logic [2:0] PSF_OP_NONPIPE = 3'h1;
  localparam logic [2:0] PSF_OP_PIPE = 3'h0;
  localparam logic [7:0] PSF_SUB_SELECT = 8'h04;
  localparam logic [7:0] PSF_SUB_FENCE = 8'h00;
  localparam logic [7:0] PSF_LEN_BIAS = 8'h02;
  localparam logic [7:0] PSF_FENCE_LEN = 8'h01;
  // fence field positions
  localparam int PSF_VS_LSB = 0;
  localparam int PSF_GS_LSB = 10;
  localparam int PSF_CLIPPING_STAGE_LSB = 20;
  localparam int PSF_SF_LSB = 0;
  localparam int PSF_VFE_LSB = 10;
  localparam int PSF_CS_LSB = 20;
  // storage sizes in 512-bit units
  localparam logic [10:0] PSF_SIZE_EARLY = 11'h100;
  localparam logic [10:0] PSF_SIZE_LATE = 11'h180;
  // function codes
  localparam logic [3:0] PSF_FFID_STREAM = 4'ha;
  localparam logic [3:0] PSF_FFID_SPAWNER = 4'h7;
  localparam logic [3:0] PSF_SPAWNER_FUNCTION_CODE = 4'h7;
  // register offsets
  localparam logic [3:0] PSF_REG_CMD = 4'h0;
  localparam logic [3:0] PSF_REG_CTX = 4'h1;
  localparam logic [3:0] PSF_REG_STATUS = 4'h2;
  localparam logic [3:0] PSF_REG_CONFIG = 4'h3;
  localparam logic [3:0] PSF_REG_FENCE0 = 4'h8;
  // reset values
  localparam logic PSF_PIPE_RST = 1'b0;
  localparam logic [10:0] PSF_FENCE_RST = 11'h000;
  // release wait after rasterizer drop, in cycles
  localparam int PSF_RELEASE_NS = 80;
  localparam int PSF_CLK_NS = 10;
  localparam logic [3:0] PSF_RELEASE_CYC =
    4'((PSF_RELEASE_NS + PSF_CLK_NS - 1) / PSF_CLK_NS);
  localparam int PSF_NFENCE = 6;

  typedef enum logic [2:0] {
    PSF_IDLE = 3'b000,
    PSF_FDW1 = 3'b001,
    PSF_FDW2 = 3'b010,
    PSF_SKIP = 3'b011,
    PSF_DRAIN = 3'b100,
    PSF_WAIT = 3'b101
  } psf_state_t;
endpackage

/* File: hdl/psf_fence_if.sv */
// Purpose: carries fence writes into the fence store
// Assumes: one write per cycle at most
// Notes: read ports return registered data
`timescale 1ns/1ns
interface psf_fence_if;
  logic wrEn;
  logic [2:0] wrIdx;
  logic [10:0] wrData;
  logic [2:0] rdIdx;
  logic [10:0] rdData;
  logic [10:0] limit;
  modport ctrl (output wrEn, output wrIdx, output wrData, output rdIdx,
    input rdData);
  modport store (input wrEn, input wrIdx, input wrData, input rdIdx,
    output rdData, input limit);
endinterface

/* File: hdl/psf_fence_store.sv */
// Purpose: holds the six fence pointers in list order
// Assumes: caller only writes fields that are currently valid
// Notes: writes above the storage size are clamped to it
`timescale 1ns/1ns
module psf_fence_store
  import psf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  psf_fence_if.store fb
);
  logic [10:0] fence_r [PSF_NFENCE];
  logic [10:0] rdData_r;

  // one flop per fence entry, clamped to the storage size
  genvar gi;
  generate
    for (gi = 0; gi < PSF_NFENCE; gi++) begin : g_fence
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          fence_r[gi] <= PSF_FENCE_RST;
        end else if (fb.wrEn && fb.wrIdx == 3'(gi)) begin
          fence_r[gi] <= (fb.wrData > fb.limit) ? fb.limit :
            fb.wrData;
        end
      end
    end
  endgenerate

  // registered read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_r <= PSF_FENCE_RST;
    end else if (fb.rdIdx < 3'(PSF_NFENCE)) begin
      rdData_r <= fence_r[fb.rdIdx];
    end else begin
      rdData_r <= PSF_FENCE_RST;
    end
  end
  assign fb.rdData = rdData_r;
endmodule

/* File: hdl/psf_release_timer.sv */
// Purpose: counts out the bus delay before old entries count as released
// Assumes: start is a one-cycle pulse
// Notes: done is a one-cycle pulse when the count ends
`timescale 1ns/1ns
module psf_release_timer
  import psf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic start,
  output logic done
);
  logic [3:0] cnt_r;
  logic done_r;

  // load on start, count down to zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 4'h0;
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == 4'h1);
      if (start) begin
        cnt_r <= PSF_RELEASE_CYC;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  assign done = done_r;
endmodule

/* File: hdl/psf_top.sv */
// Purpose: pipe select and storage fence command handling
// Assumes: dwords are fed through the command register, one per write
// Notes: the flush and rasterizer handshake are ports to the pipelines
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module psf_top
  import psf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic deallocFlush3d,
  output logic deallocFlushMedia,
  input wire logic rastDropDone,
  output logic mediaSelected,
  output logic [3:0] streamFuncCode,
  output logic [3:0] spawnerFuncCode
);
  psf_state_t state_r;
  psf_state_t state_nxt;
  logic pipe_r;
  logic pendPipe_r;
  logic curbeValid_r;
  logic curbeOwner_r;
  logic lateSize_r;
  logic badCmd_r;
  logic fenceSeen_r;
  logic [31:0] dw1_r;
  logic [31:0] regRdata_r;
  logic flush3d_r;
  logic flushMedia_r;
  logic rastSync1_r;
  logic rastSync2_r;
  logic relStart;
  logic relDone;
  logic [7:0] skipCnt_r;
  logic cmdWr;
  logic isSelect;
  logic isFence;
  logic [10:0] limit;
  logic [10:0] cur;
  psf_fence_if fb ();

  assign cmdWr = regWr && regAddr == PSF_REG_CMD;
  assign limit = lateSize_r ? PSF_SIZE_LATE : PSF_SIZE_EARLY;
  assign fb.limit = limit;

  // header decode of the two commands
  assign isSelect = regWdata[31:29] == PSF_TYPE_GFX &&
    regWdata[28:27] == PSF_SUBTYPE_COMMON &&
    regWdata[26:24] == PSF_OP_NONPIPE &&
    regWdata[23:16] == PSF_SUB_SELECT;
  assign isFence = regWdata[31:29] == PSF_TYPE_GFX &&
    regWdata[28:27] == PSF_SUBTYPE_COMMON &&
    regWdata[26:24] == PSF_OP_PIPE &&
    regWdata[23:16] == PSF_SUB_FENCE;

  // synchronise the rasterizer drop acknowledge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rastSync1_r <= 1'b0;
      rastSync2_r <= 1'b0;
    end else begin
      rastSync1_r <= rastDropDone;
      rastSync2_r <= rastSync1_r;
    end
  end

  // next state of the command sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PSF_IDLE: begin
        if (cmdWr && isSelect && regWdata[0] != pipe_r) begin
          state_nxt = PSF_DRAIN;
        end else if (cmdWr && isFence) begin
          state_nxt = PSF_FDW1;
        end
      end
      PSF_FDW1: if (cmdWr) state_nxt = PSF_FDW2;
      PSF_FDW2: begin
        if (cmdWr) begin
          state_nxt = (skipCnt_r == 8'h0) ? PSF_IDLE : PSF_SKIP;
        end
      end
      PSF_SKIP: begin
        if (cmdWr && skipCnt_r == 8'h1) state_nxt = PSF_IDLE;
      end
      PSF_DRAIN: if (rastSync2_r) state_nxt = PSF_WAIT;
      PSF_WAIT: if (relDone) state_nxt = PSF_IDLE;
      default: state_nxt = PSF_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= PSF_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign relStart = state_r == PSF_DRAIN && rastSync2_r;

  psf_release_timer u_timer (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(relStart),
    .done(relDone)
  );

  // selected pipe, switched by a select once old entries are released, or at once by a context write made while the sequencer is idle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pipe_r <= PSF_PIPE_RST;
      pendPipe_r <= PSF_PIPE_RST;
    end else if (state_r == PSF_IDLE && cmdWr && isSelect) begin
      pendPipe_r <= regWdata[0];
    end else if (state_r == PSF_WAIT && relDone) begin
      pipe_r <= pendPipe_r;
    end else if (state_r == PSF_IDLE && regWr &&
        regAddr == PSF_REG_CTX) begin
      pipe_r <= regWdata[0];
      pendPipe_r <= regWdata[0];
    end
  end

  // deallocating flush pulse to the pipe being left
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flush3d_r <= 1'b0;
      flushMedia_r <= 1'b0;
    end else begin
      flush3d_r <= state_r == PSF_IDLE && state_nxt == PSF_DRAIN &&
        !pipe_r;
      flushMedia_r <= state_r == PSF_IDLE && state_nxt == PSF_DRAIN &&
        pipe_r;
    end
  end

  // constant entry reference owner
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      curbeValid_r <= 1'b0;
      curbeOwner_r <= PSF_PIPE_RST;
    end else if (state_r == PSF_WAIT && relDone &&
        curbeOwner_r != pendPipe_r) begin
      curbeValid_r <= 1'b0;
    end else if (regWr && regAddr == PSF_REG_CONFIG && regWdata[1]) begin
      curbeValid_r <= 1'b1;
      curbeOwner_r <= pipe_r;
    end
  end

  // configuration: storage size and malformed-command flag
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lateSize_r <= 1'b0;
      badCmd_r <= 1'b0;
      fenceSeen_r <= 1'b0;
    end else begin
      if (regWr && regAddr == PSF_REG_CONFIG) lateSize_r <= regWdata[0];
      if (state_r == PSF_IDLE && cmdWr &&
          ((isSelect && regWdata[15:1] != 15'h0) ||
           (isFence && regWdata[15:14] != 2'h0))) begin
        badCmd_r <= 1'b1;
      end else if (regWr && regAddr == PSF_REG_STATUS && regWdata[0]) begin
        badCmd_r <= 1'b0;
      end
      if (state_r == PSF_FDW2 && cmdWr) fenceSeen_r <= 1'b1;
    end
  end

  // length tracking and dword 1 capture
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      skipCnt_r <= 8'h0;
      dw1_r <= 32'h0;
    end else if (state_r == PSF_IDLE && cmdWr && isFence) begin
      skipCnt_r <= (regWdata[7:0] > PSF_FENCE_LEN) ?
        8'(regWdata[7:0] - PSF_FENCE_LEN) : 8'h0;
    end else if (state_r == PSF_FDW1 && cmdWr) begin
      dw1_r <= regWdata;
    end else if (state_r == PSF_SKIP && cmdWr) begin
      skipCnt_r <= skipCnt_r - 8'h1;
    end
  end

  // fence write of the CS field on dword 2, made whichever pipe is selected
  always_comb begin
    fb.wrEn = 1'b0;
    fb.wrIdx = 3'h0;
    fb.wrData = PSF_FENCE_RST;
    if (state_r == PSF_FDW2 && cmdWr) begin
      fb.wrEn = 1'b1;
      fb.wrIdx = 3'h5;
      fb.wrData = regWdata[PSF_CS_LSB +: 11];
    end
  end

  // 3D fences from dword 1 and the SF or VFE fence from dword 2, applied one per cycle
  logic [2:0] fseq_r;
  logic [31:0] dw2_r;
  psf_fence_if fb2 ();
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fseq_r <= 3'h0;
      dw2_r <= 32'h0;
    end else if (state_r == PSF_FDW2 && cmdWr) begin
      fseq_r <= 3'h1;
      dw2_r <= regWdata;
    end else if (fseq_r != 3'h0) begin
      fseq_r <= (fseq_r == 3'h4) ? 3'h0 : fseq_r + 3'h1;
    end
  end

  // per-field write from the sequenced step, unselected pipe skipped
  always_comb begin
    fb2.wrEn = 1'b0;
    fb2.wrIdx = 3'h0;
    fb2.wrData = PSF_FENCE_RST;
    unique case (fseq_r)
      3'h1: begin
        fb2.wrEn = !pipe_r;
        fb2.wrIdx = 3'h0;
        fb2.wrData = {1'b0, dw1_r[PSF_VS_LSB +: 10]};
      end
      3'h2: begin
        fb2.wrEn = !pipe_r;
        fb2.wrIdx = 3'h1;
        fb2.wrData = {1'b0, dw1_r[PSF_GS_LSB +: 10]};
      end
      3'h3: begin
        fb2.wrEn = !pipe_r;
        fb2.wrIdx = 3'h2;
        fb2.wrData = {1'b0, dw1_r[PSF_CLIPPING_STAGE_LSB +: 10]};
      end
      3'h4: begin
        fb2.wrEn = 1'b1;
        fb2.wrIdx = pipe_r ? 3'h4 : 3'h3;
        fb2.wrData = pipe_r ? {1'b0, dw2_r[PSF_VFE_LSB +: 10]} :
          {1'b0, dw2_r[PSF_SF_LSB +: 10]};
      end
      default: begin
        fb2.wrEn = 1'b0;
      end
    endcase
  end

  // merge both write sources into the store; the dword 2 write wins when they coincide
  psf_fence_if fbm ();
  assign fbm.wrEn = fb.wrEn || fb2.wrEn;
  assign fbm.wrIdx = fb.wrEn ? fb.wrIdx : fb2.wrIdx;
  assign fbm.wrData = fb.wrEn ? fb.wrData : fb2.wrData;
  assign fbm.rdIdx = regAddr[2:0];
  assign fbm.limit = limit;
  assign fb.rdData = fbm.rdData;
  assign fb.rdIdx = regAddr[2:0];
  assign fb2.rdIdx = 3'h0;
  assign fb2.rdData = PSF_FENCE_RST;
  assign fb2.limit = limit;

  psf_fence_store u_store (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .fb(fbm)
  );

  // fence read back; a region runs from the previous fence to this one
  always_comb begin
    cur = fbm.rdData;
  end

  // register read data, valid the cycle after the read strobe
  logic rdFence_r;
  logic [31:0] rdOther_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdFence_r <= 1'b0;
      rdOther_r <= 32'h0;
    end else begin
      rdFence_r <= regRd && regAddr[3];
      rdOther_r <= 32'h0;
      if (regRd) begin
        unique case (regAddr)
          PSF_REG_CTX: rdOther_r <= {31'h0, pipe_r};
          PSF_REG_STATUS: rdOther_r <= {26'h0, fenceSeen_r,
            curbeOwner_r, curbeValid_r, 1'b0, state_r == PSF_IDLE,
            badCmd_r};
          PSF_REG_CONFIG: rdOther_r <= {31'h0, lateSize_r};
          default: rdOther_r <= 32'h0;
        endcase
      end
    end
  end
  assign regRdata_r = rdFence_r ? {21'h0, cur} : rdOther_r;
  assign regRdata = regRdata_r;

  assign deallocFlush3d = flush3d_r;
  assign deallocFlushMedia = flushMedia_r;
  assign mediaSelected = pipe_r;
  assign streamFuncCode = PSF_FFID_STREAM;
  assign spawnerFuncCode = PSF_SPAWNER_FUNCTION_CODE;
endmodule

/* File: verification/psf_top_props.sv */
// Purpose: port-level properties of the pipe select and fence block
// Assumes: one clock domain, async active-low reset
// Notes: bound into every psf_top instance
`timescale 1ns/1ns
module psf_top_chk
  import psf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic deallocFlush3d,
  input wire logic deallocFlushMedia,
  input wire logic rastDropDone,
  input wire logic mediaSelected,
  input wire logic [3:0] streamFuncCode,
  input wire logic [3:0] spawnerFuncCode
);
  logic [4:0] dropAge_r;

  // cycles since the rasterizer last acknowledged, saturating
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dropAge_r <= 5'h1f;
    end else if (rastDropDone) begin
      dropAge_r <= 5'h00;
    end else if (dropAge_r != 5'h1f) begin
      dropAge_r <= dropAge_r + 5'h01;
    end
  end

  property p_codes;
    @(posedge sys_clk) disable iff (!arst_n)
      streamFuncCode == PSF_FFID_STREAM && spawnerFuncCode == PSF_SPAWNER_FUNCTION_CODE;
  endproperty
  a_codes: assert property (p_codes) else $error("bad func code");

  property p_f3d;
    @(posedge sys_clk) disable iff (!arst_n)
      deallocFlush3d |-> !mediaSelected && $past(regWr) && $past(regWdata[0]);
  endproperty
  a_f3d: assert property (p_f3d) else $error("stray 3d flush");

  property p_fmed;
    @(posedge sys_clk) disable iff (!arst_n)
      deallocFlushMedia |-> mediaSelected && $past(regWr) &&
        !$past(regWdata[0]);
  endproperty
  a_fmed: assert property (p_fmed) else $error("stray media flush");

  property p_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(deallocFlush3d) |=> !mediaSelected [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("switched early");

  property p_bound;
    @(posedge sys_clk) disable iff (!arst_n)
      deallocFlush3d |-> ##[9:60] mediaSelected;
  endproperty
  a_bound: assert property (p_bound) else $error("switch never done");

  property p_release;
    @(posedge sys_clk) disable iff (!arst_n)
      $changed(mediaSelected) |-> $past(regWr && regAddr == PSF_REG_CTX) ||
        (dropAge_r >= 5'h07 && dropAge_r <= 5'h0e);
  endproperty
  a_release: assert property (p_release) else $error("no release");

  property p_ctx;
    @(posedge sys_clk) disable iff (!arst_n)
      $past(regRd && regAddr == PSF_REG_CTX) |->
        regRdata == {31'h0, $past(mediaSelected)};
  endproperty
  a_ctx: assert property (p_ctx) else $error("context bit wrong");

  property p_fence;
    @(posedge sys_clk) disable iff (!arst_n)
      $past(regRd && regAddr >= PSF_REG_FENCE0 && regAddr <= 4'hd) |->
        regRdata <= {21'h0, PSF_SIZE_LATE};
  endproperty
  a_fence: assert property (p_fence) else $error("fence above size");
endmodule

bind psf_top psf_top_chk i_psf_top_chk (.sys_clk, .arst_n, .regAddr,
  .regWdata, .regWr, .regRd, .regRdata, .deallocFlush3d,
  .deallocFlushMedia, .rastDropDone, .mediaSelected, .streamFuncCode,
  .spawnerFuncCode);

/* File: verification/psf_rast_model.sv */
// Purpose: rasterizer side answering deallocating flushes
// Assumes: flush inputs are one-cycle pulses
// Notes: ackDelay sets how long current work takes before the drop
`timescale 1ns/1ns
module psf_rast_model
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic deallocFlush3d,
  input wire logic deallocFlushMedia,
  input wire logic [5:0] ackDelay,
  output logic rastDropDone
);
  logic [5:0] cnt_r;
  logic busy_r;
  logic [1:0] hold_r;

  // finish current tasks, then drop the constant entry for two cycles
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'h0;
      cnt_r <= 6'h00;
      hold_r <= 2'h0;
    end else if (deallocFlush3d || deallocFlushMedia) begin
      busy_r <= 1'h1;
      cnt_r <= ackDelay;
    end else if (busy_r && cnt_r != 6'h00) begin
      cnt_r <= cnt_r - 6'h01;
    end else if (busy_r) begin
      busy_r <= 1'h0;
      hold_r <= 2'h2;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end
  assign rastDropDone = (hold_r != 2'h0);
endmodule

/* File: verification/tb.sv */
// Purpose: self-checking bench for the pipe select and fence block
// Assumes: the pipeline is flushed before every select
// Notes: fence rows first, awkward cases after
`timescale 1ns/1ns
module tb
  import psf_pkg::*;
;
  typedef struct {
    logic media;
    logic [31:0] dw1;
    logic [31:0] dw2;
  } psf_row_t;
  logic sys_clk, arst_n, regWr, regRd, rastDropDone, mediaSelected, cur;
  logic deallocFlush3d, deallocFlushMedia;
  logic [3:0] regAddr, streamFuncCode, spawnerFuncCode;
  logic [31:0] regWdata, regRdata, rdVal;
  logic [5:0] ackDelay;
  logic [10:0] expF [6];
  int bad_count, num_checks;
  psf_row_t rows [4] = '{
    '{1'h0, 32'h06010020, 32'h0c024080},
    '{1'h0, 32'h3ff04010, 32'h7ff157ff},
    '{1'h1, 32'h01402010, 32'h0f014033},
    '{1'h0, 32'h0c820040, 32'h0ff000d0}};

  psf_top i_psf_top (.sys_clk, .arst_n, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .deallocFlush3d, .deallocFlushMedia, .rastDropDone,
    .mediaSelected, .streamFuncCode, .spawnerFuncCode);
  psf_rast_model i_psf_rast_model (.sys_clk, .arst_n, .deallocFlush3d,
    .deallocFlushMedia, .ackDelay, .rastDropDone);

  // 100 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge sys_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= v;
    @(posedge sys_clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge sys_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1 rdVal = regRdata;
  endtask
  function automatic logic [10:0] cl(logic [10:0] v);
    return (v > 11'h100) ? 11'h100 : v;
  endfunction
  task automatic fence(logic m, logic [31:0] d1, logic [31:0] d2, logic u);
    wr(PSF_REG_CMD, 32'h60000001);
    wr(PSF_REG_CMD, d1);
    wr(PSF_REG_CMD, d2);
    repeat (8) @(posedge sys_clk);
    // expected fences, clamped to storage size
    if (u && !m) begin
      expF[0] = cl({1'h0, d1[9:0]});
      expF[1] = cl({1'h0, d1[19:10]});
      expF[2] = cl({1'h0, d1[29:20]});
      expF[3] = cl({1'h0, d2[9:0]});
    end else if (u) begin
      expF[4] = cl({1'h0, d2[19:10]});
    end
    if (u) expF[5] = cl(d2[30:20]);
  endtask
  task automatic chk_fences();
    for (int i = 0; i < 6; i++) begin
      rd(PSF_REG_FENCE0 + 4'(i));
      chk("fence", {21'h0, expF[i]}, rdVal);
    end
  endtask
  task automatic sel(logic m);
    wr(PSF_REG_CMD, {31'h30820000, m});
    #1;
    chk("flush", 32'h1, 32'(m ? deallocFlush3d : deallocFlushMedia));
  endtask
  task automatic wait_sel(logic m);
    int n;
    n = 0;
    while (mediaSelected !== m && n < 60) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("pipe", {31'h0, m}, {31'h0, mediaSelected});
    if (mediaSelected !== m) give_verdict();
  endtask

  // main sequence
  initial begin
    arst_n = 1'h0;
    regWr = 1'h0;
    regRd = 1'h0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    ackDelay = 6'h03;
    cur = 1'h0;
    expF = '{default: 11'h0};
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'h1;
    #1;
    chk("codes", 32'ha7, {24'h0, streamFuncCode, spawnerFuncCode});
    chk("pipe", 32'h0, {31'h0, mediaSelected});
    chk_fences();
    rd(4'hf);
    chk("unmapped", 32'h0, rdVal);
    foreach (rows[r]) begin
      if (rows[r].media !== cur) begin
        sel(rows[r].media);
        wait_sel(rows[r].media);
        cur = rows[r].media;
      end
      fence(rows[r].media, rows[r].dw1, rows[r].dw2, 1'h1);
      chk_fences();
    end
    // select of the current pipe sends no flush
    wr(PSF_REG_CMD, 32'h61040000);
    repeat (3) begin
      #1;
      chk("noflush", 32'h0, 32'(deallocFlush3d | deallocFlushMedia));
      @(posedge sys_clk);
    end
    // context save and restore of the pipe bit
    wr(PSF_REG_CTX, 32'h1);
    wait_sel(1'h1);
    rd(PSF_REG_CTX);
    chk("ctx", 32'h1, rdVal);
    wr(PSF_REG_CTX, 32'h0);
    wait_sel(1'h0);
    // fence writes during a slow drain are dropped
    ackDelay <= 6'h14;
    sel(1'h1);
    fence(1'h1, 32'h0, 32'h01100000, 1'h0);
    wait_sel(1'h1);
    chk_fences();
    // late size, constant owner, malformed select, extra dwords skipped
    wr(PSF_REG_CONFIG, 32'h3);
    wr(PSF_REG_CMD, 32'h61040003);
    rd(PSF_REG_STATUS);
    chk("status", 32'h3b, rdVal);
    wr(PSF_REG_STATUS, 32'h1);
    wr(PSF_REG_CMD, 32'h60000003);
    wr(PSF_REG_CMD, 32'h0);
    wr(PSF_REG_CMD, 32'h1ff50000);
    wr(PSF_REG_CMD, 32'h60000001);
    wr(PSF_REG_CMD, 32'h60000001);
    repeat (8) @(posedge sys_clk);
    rd(PSF_REG_STATUS);
    chk("status", 32'h3a, rdVal);
    expF[4] = 11'h140;
    expF[5] = 11'h180;
    chk_fences();
    // switching away from the owner drops the constant reference
    sel(1'h0);
    wait_sel(1'h0);
    rd(PSF_REG_STATUS);
    chk("status", 32'h32, rdVal);
    wr(PSF_REG_CTX, 32'h1);
    wait_sel(1'h1);
    // second reset in mid-run
    arst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'h1;
    expF = '{default: 11'h0};
    #1 chk("pipe", 32'h0, {31'h0, mediaSelected});
    chk_fences();
    give_verdict();
  end
endmodule
